/* File: inc/sdrc_consts.svh */
// constants for the disconnect/reconnect policy block
`ifndef SDRC_CONSTS_SVH
`define SDRC_CONSTS_SVH
`define SDRC_RATIO_DEN_LOG2   8
`define SDRC_BLOCK_BYTES      512
`define SDRC_OP_READ6         8'h08
`define SDRC_OP_READ10        8'h28
`define SDRC_OP_WRITE6        8'h0A
`define SDRC_OP_WRITE10       8'h2A
`define SDRC_OP_WRVERIFY      8'h2E
`define SDRC_OP_WRSAME        8'h41
`define SDRC_TDP_NONE         2'h0
`define SDRC_TDP_DATA         2'h1
`define SDRC_TDP_RSVD         2'h2
`define SDRC_TDP_CMD          2'h3
`define SDRC_SK_ILLEGAL       4'h5
`define SDRC_ASC_BAD_PARAM    8'h26
`define SDRC_NOTCH_ALL        4'h0
`endif

/* File: inc/sdrc_pkg.sv */
// types of the disconnect/reconnect policy block
package sdrc_pkg;
	typedef enum logic [5:0] {
		SDRC_IDLE  = 6'b000001,	// off the bus, no command
		SDRC_CMD   = 6'b000010,	// command received, deciding
		SDRC_WAIT  = 6'b000100,	// disconnected, waiting threshold
		SDRC_XFER  = 6'b001000,	// connected, moving data
		SDRC_FINSH = 6'b010000,	// data done, awaiting completion
		SDRC_ERR   = 6'b100000	// check condition status
	} sdrc_state_e;
endpackage

/* File: rtl/sdrc_fifo.sv */
// small valid/ready fifo in the data path
`timescale 1ns/100ps
module sdrc_fifo #(
	parameter int WIDTH = 8,	// word width
	parameter int DEPTH = 4	// number of words
) (
	input  wire logic             mclk,	// clock
	input  wire logic             arst_n,	// async reset, low
	input  wire logic [WIDTH-1:0] in_data,	// fill side data
	input  wire logic             in_valid,	// fill side valid
	output logic                  in_ready,	// fill side ready
	output logic [WIDTH-1:0]      out_data,	// drain side data
	output logic                  out_valid,	// drain side valid
	input  wire logic             out_ready	// drain side ready
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem [DEPTH];	// storage
	logic [AW-1:0]    wp_reg;	// write pointer
	logic [AW-1:0]    rp_reg;	// read pointer
	logic [AW:0]      cnt_reg;	// fill count
	logic             push;	// word accepted
	logic             pop;	// word drained

	assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
	assign out_valid = (cnt_reg != '0);
	assign out_data  = mem[rp_reg];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// storage writes, no reset needed
	always_ff @(posedge mclk) begin
		if (push) begin
			mem[wp_reg] <= in_data;
		end
	end

	// pointers and count
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			wp_reg  <= '0;
			rp_reg  <= '0;
			cnt_reg <= '0;
		end else begin
			if (push) begin
				wp_reg <= (wp_reg == AW'(DEPTH-1)) ? '0 : wp_reg + 1'b1;
			end
			if (pop) begin
				rp_reg <= (rp_reg == AW'(DEPTH-1)) ? '0 : rp_reg + 1'b1;
			end
			cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// fill count never passes depth
	a_fifo_bound: assert property (@(posedge mclk) disable iff (!arst_n)
		cnt_reg <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule

/* File: rtl/sdrc_core.sv */
// disconnect/reconnect policy for the target side of a parallel bus
// Notes on behaviour
// [RULE1] read reconnect when buffer fill reaches ratio/256
// [RULE2] write reconnect when buffer empty reaches ratio/256
// [RULE3] zero ratio uses rate-derived optimal threshold
// [RULE4] burst limit counted in whole blocks
// [RULE5] disconnect only on block boundaries
// [RULE6] tiny burst still moves one block
// [RULE7] burst zero means no limit
// [RULE8] disconnect when segment empty/full mid-phase
// [RULE9] disconnect-immediate disconnects before any data phase
// [RULE10] priority commands never disconnect
// [RULE11] writes stay connected until data-out unless queued
// [RULE12] started data-out may disconnect
// [RULE13] buffered read starts without disconnect unless queued
// [RULE14] unbuffered read disconnects until full threshold
// [RULE15] policy 00 defers, 10 reserved
// [RULE16] policy 01 holds connection until data done
// [RULE17] policy 11 holds connection until command done
// [RULE18] policy and burst both nonzero: check condition
// [RULE19] nonzero fairness field enables fair arbitration
// [RULE20] initiator grants privilege, may reject disconnect
// [RULE21] thresholds apply to listed read/write opcodes
// [RULE22] per-notch ratios, notch zero sets all
// [RULE23] latch parameters on update, apply next command; ratio tables apply at once, also mid-command
`timescale 1ns/100ps
`include "sdrc_consts.svh"
module sdrc_core #(
	parameter int BUF_W    = 16,	// buffer fill count width
	parameter int NOTCHES  = 4,	// number of zone notches
	parameter int DATA_W   = 8,	// data word width
	parameter int FIFO_D   = 4	// data fifo depth
) (
	input  wire logic              mclk,	// clock 100 MHz
	input  wire logic              arst_n,	// async reset, low
	input  wire logic              prm_load,	// parameter update accepted
	input  wire logic [3:0]        prm_notch,	// notch to update, 0 all
	input  wire logic [7:0]        prm_rd_ratio,	// read full ratio
	input  wire logic [7:0]        prm_wr_ratio,	// write empty ratio
	input  wire logic [15:0]       prm_burst,	// burst limit in blocks
	input  wire logic              prm_disc_imm,	// disconnect_immediate
	input  wire logic [1:0]        prm_xfer_pol,	// transfer_disconnect_policy
	input  wire logic [2:0]        prm_fair,	// fair arbitration field
	input  wire logic [3:0]        active_notch,	// current zone notch
	input  wire logic [7:0]        opt_ratio,	// rate-derived optimal ratio
	input  wire logic              cmd_valid,	// command received pulse
	input  wire logic [7:0]        cmd_opcode,	// command opcode
	input  wire logic              cmd_priority,	// priority command
	input  wire logic              cmd_queued,	// command must be queued
	input  wire logic              cmd_hit,	// read data already buffered
	input  wire logic              disc_grant,	// identify granted privilege
	input  wire logic              msg_reject,	// initiator rejected disconnect
	input  wire logic [BUF_W-1:0]  buf_fill,	// buffer fill count
	input  wire logic [BUF_W-1:0]  buf_size,	// buffer size
	input  wire logic [15:0]       xfer_blocks,	// blocks left in command
	input  wire logic              cmd_done,	// command complete pulse
	input  wire logic [DATA_W-1:0] dat_in,	// data word from source
	input  wire logic              dat_in_valid,	// source valid
	output logic                   dat_in_ready,	// source ready
	input  wire logic              dat_last,	// word ends a block
	output logic [DATA_W-1:0]      dat_out,	// data word to bus
	output logic                   dat_out_valid,	// bus side valid
	input  wire logic              dat_out_ready,	// bus side ready
	output logic                   connected,	// target holds the bus
	output logic                   disc_req,	// request disconnect
	output logic                   reconn_req,	// request reselection
	output logic                   fair_arb,	// use fair arbitration
	output logic                   chk_cond,	// check condition status
	output logic [3:0]             sense_key,	// sense key
	output logic [7:0]             sense_asc	// additional sense code
);
	localparam int NW = $clog2(NOTCHES);

	// policy state in one record, ratio tables and shadow copies kept apart
	typedef struct packed {
		sdrc_pkg::sdrc_state_e st;	// policy state
		logic [15:0]        burst;	// latched burst limit
		logic               imm;	// latched disconnect immediate
		logic [1:0]         pol;	// latched transfer policy
		logic               fair;	// latched fairness enable
		logic [15:0]        bcnt;	// blocks moved this burst
		logic               is_rd;	// command is a read
		logic               is_wr;	// command is a write
		logic               prio;	// priority command
		logic               hold;	// stay connected by policy
		logic               conn;	// connected
		logic               disc;	// disconnect request
		logic               reconn;	// reconnect request
		logic               chk;	// check condition
		logic [7:0]         pend_rd;	// pending read ratio staged
		logic [7:0]         pend_wr;	// pending write ratio staged
	} sdrc_state_s;

	sdrc_state_s s_reg;	// registered state
	sdrc_state_s s_next;	// next state
	logic [7:0]  rd_tab [NOTCHES];	// per-notch read ratios
	logic [7:0]  wr_tab [NOTCHES];	// per-notch write ratios
	logic [15:0] burst_sh;	// shadow burst from last update
	logic        imm_sh;	// shadow disconnect immediate
	logic [1:0]  pol_sh;	// shadow transfer policy
	logic        fair_sh;	// shadow fairness
	logic [7:0]  rd_ratio;	// effective read ratio
	logic [7:0]  wr_ratio;	// effective write ratio
	logic        rd_ok;	// read threshold met
	logic        wr_ok;	// write threshold met
	logic        blk_end;	// block boundary on bus side
	logic        f_valid;	// fifo output valid
	logic        f_ready;	// fifo output ready
	logic [NW-1:0] notch_ix;	// notch index

	// opcode class decoders
	function automatic logic is_read_op(input logic [7:0] op);
		return (op == `SDRC_OP_READ6) || (op == `SDRC_OP_READ10);	// RULE21
	endfunction
	function automatic logic is_write_op(input logic [7:0] op);
		return (op == `SDRC_OP_WRITE6) || (op == `SDRC_OP_WRITE10) ||
			(op == `SDRC_OP_WRVERIFY) || (op == `SDRC_OP_WRSAME);
	endfunction
	// threshold compare: fill*256 >= ratio*size
	function automatic logic ratio_met(input logic [BUF_W-1:0] amt,
		input logic [BUF_W-1:0] size, input logic [7:0] ratio);
		return ({amt, 8'h00} >= ((BUF_W+8)'(ratio) * (BUF_W+8)'(size)));
	endfunction

	// data fifo, drained only while connected
	sdrc_fifo #(.WIDTH(DATA_W + 1), .DEPTH(FIFO_D)) u_fifo (
		.mclk      (mclk),
		.arst_n    (arst_n),
		.in_data   ({dat_last, dat_in}),
		.in_valid  (dat_in_valid),
		.in_ready  (dat_in_ready),
		.out_data  ({blk_end, dat_out}),
		.out_valid (f_valid),
		.out_ready (f_ready)
	);
	assign dat_out_valid = f_valid && (s_reg.st == sdrc_pkg::SDRC_XFER);
	assign f_ready       = dat_out_ready && (s_reg.st == sdrc_pkg::SDRC_XFER);

	// per-notch read and write ratio tables
	generate
		for (genvar n = 0; n < NOTCHES; n++) begin : g_notch
			always_ff @(posedge mclk or negedge arst_n) begin
				if (!arst_n) begin
					rd_tab[n] <= 8'h00;
					wr_tab[n] <= 8'h00;
				end else if (prm_load && ((prm_notch == `SDRC_NOTCH_ALL) ||
					(prm_notch == 4'(n)))) begin
					rd_tab[n] <= prm_rd_ratio;	// RULE22
					wr_tab[n] <= prm_wr_ratio;
				end
			end
		end
	endgenerate

	// shadow copy taken on update, applied at next command
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			burst_sh <= 16'h0000;
			imm_sh   <= 1'b0;
			pol_sh   <= `SDRC_TDP_NONE;
			fair_sh  <= 1'b0;
		end else if (prm_load) begin
			burst_sh <= prm_burst;	// RULE23
			imm_sh   <= prm_disc_imm;
			pol_sh   <= prm_xfer_pol;
			fair_sh  <= (prm_fair != 3'h0);	// RULE19
		end
	end

	assign notch_ix = NW'(active_notch);
	assign rd_ratio = (rd_tab[notch_ix] == 8'h00) ? opt_ratio : rd_tab[notch_ix];	// RULE3
	assign wr_ratio = (wr_tab[notch_ix] == 8'h00) ? opt_ratio : wr_tab[notch_ix];	// RULE3
	assign rd_ok    = ratio_met(buf_fill, buf_size, rd_ratio);	// RULE1
	assign wr_ok    = ratio_met(buf_size - buf_fill, buf_size, wr_ratio);	// RULE2

	// policy state machine
	always_comb begin
		s_next        = s_reg;
		s_next.disc   = 1'b0;
		s_next.reconn = 1'b0;
		unique case (s_reg.st)
			sdrc_pkg::SDRC_IDLE: begin
				if (cmd_valid) begin
					// latch parameters for this command
					s_next.burst = burst_sh;	// RULE23
					s_next.imm   = imm_sh;
					s_next.pol   = pol_sh;
					s_next.fair  = fair_sh;
					s_next.is_rd = is_read_op(cmd_opcode);	// RULE21
					s_next.is_wr = is_write_op(cmd_opcode);
					s_next.prio  = cmd_priority;
					s_next.hold  = 1'b0;
					s_next.bcnt  = 16'h0000;
					s_next.conn  = 1'b1;
					s_next.chk   = 1'b0;
					s_next.st    = sdrc_pkg::SDRC_CMD;
				end
			end
			sdrc_pkg::SDRC_CMD: begin
				if ((s_reg.pol != `SDRC_TDP_NONE) && (s_reg.burst != 16'h0000)) begin
					s_next.chk = 1'b1;	// RULE18
					s_next.st  = sdrc_pkg::SDRC_ERR;
				end else if (s_reg.prio) begin
					s_next.st = sdrc_pkg::SDRC_XFER;	// RULE10
				end else if (disc_grant && !msg_reject && (s_reg.imm || cmd_queued ||
					(s_reg.is_rd && !cmd_hit))) begin
					// disconnect before data phase
					s_next.disc = 1'b1;	// RULE9 RULE11 RULE13 RULE14 RULE20
					s_next.conn = 1'b0;
					s_next.st   = sdrc_pkg::SDRC_WAIT;
				end else begin
					s_next.st = sdrc_pkg::SDRC_XFER;	// RULE11 RULE13
				end
			end
			sdrc_pkg::SDRC_WAIT: begin
				if ((s_reg.is_rd && rd_ok) || (s_reg.is_wr && wr_ok) ||
					!(s_reg.is_rd || s_reg.is_wr)) begin
					s_next.reconn = 1'b1;	// RULE14 RULE1 RULE2
					s_next.conn   = 1'b1;
					s_next.bcnt   = 16'h0000;
					s_next.st     = sdrc_pkg::SDRC_XFER;
				end
			end
			sdrc_pkg::SDRC_XFER: begin
				if (s_reg.pol == `SDRC_TDP_DATA || s_reg.pol == `SDRC_TDP_CMD) begin
					s_next.hold = 1'b1;	// RULE16 RULE17
				end
				if (f_valid && f_ready && blk_end) begin
					// block boundary reached
					s_next.bcnt = s_reg.bcnt + 16'h0001;	// RULE4
					if (xfer_blocks <= 16'h0001) begin
						s_next.st = sdrc_pkg::SDRC_FINSH;
					end else if (!s_reg.prio && !s_next.hold && disc_grant &&
						!msg_reject &&
						(((s_reg.burst != 16'h0000) &&
						(s_reg.bcnt + 16'h0001 >= s_reg.burst)) ||	// RULE6 RULE7
						(s_reg.is_rd && buf_fill <= BUF_W'(1)) ||	// RULE8
						(s_reg.is_wr && buf_fill >= buf_size))) begin
						s_next.disc = 1'b1;	// RULE5 RULE12
						s_next.conn = 1'b0;
						s_next.st   = sdrc_pkg::SDRC_WAIT;
					end
				end
			end
			sdrc_pkg::SDRC_FINSH: begin
				if (cmd_done) begin
					s_next.conn = 1'b0;	// RULE17
					s_next.hold = 1'b0;
					s_next.st   = sdrc_pkg::SDRC_IDLE;
				end else if (s_reg.pol != `SDRC_TDP_CMD && !s_reg.prio &&
					disc_grant && !msg_reject && s_reg.conn) begin
					s_next.disc = 1'b1;	// RULE16 RULE15
					s_next.conn = 1'b0;
				end
			end
			sdrc_pkg::SDRC_ERR: begin
				if (cmd_done) begin
					s_next.conn = 1'b0;
					s_next.chk  = 1'b0;	// RULE18
					s_next.st   = sdrc_pkg::SDRC_IDLE;
				end
			end
			default: begin
				s_next.st = sdrc_pkg::SDRC_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			s_reg    <= '0;
			s_reg.st <= sdrc_pkg::SDRC_IDLE;
		end else begin
			s_reg <= s_next;
		end
	end

	assign connected  = s_reg.conn;
	assign disc_req   = s_reg.disc;
	assign reconn_req = s_reg.reconn;
	assign fair_arb   = s_reg.fair;
	assign chk_cond   = s_reg.chk;
	assign sense_key  = s_reg.chk ? `SDRC_SK_ILLEGAL : 4'h0;	// RULE18
	assign sense_asc  = s_reg.chk ? `SDRC_ASC_BAD_PARAM : 8'h00;

	// error path when policy and burst both nonzero
	a_chk_both: assert property (@(posedge mclk) disable iff (!arst_n)
		(s_reg.st == sdrc_pkg::SDRC_CMD && s_reg.pol != 2'h0 && s_reg.burst != 16'h0)
		|=> chk_cond && sense_key == 4'h5) else $error("missing check condition");	// RULE18
	// priority commands never ask to disconnect
	a_prio_stays: assert property (@(posedge mclk) disable iff (!arst_n)
		s_reg.prio && s_reg.st != sdrc_pkg::SDRC_IDLE |-> !disc_req)
		else $error("priority command disconnected");	// RULE10
	// immediate disconnect when bit set
	a_imm_disc: assert property (@(posedge mclk) disable iff (!arst_n)
		(s_reg.st == sdrc_pkg::SDRC_CMD && s_reg.imm && !s_reg.prio && disc_grant
		&& !msg_reject && s_reg.pol == 2'h0 && s_reg.burst == 16'h0) |=> disc_req && !connected)
		else $error("no immediate disconnect");	// RULE9
	// held transfer never disconnects
	a_hold_conn: assert property (@(posedge mclk) disable iff (!arst_n)
		s_reg.st == sdrc_pkg::SDRC_XFER && s_reg.hold |=> !disc_req)
		else $error("disconnect during held transfer");	// RULE16
	// policy 11 keeps bus until done
	a_cmd_hold: assert property (@(posedge mclk) disable iff (!arst_n)
		s_reg.st == sdrc_pkg::SDRC_FINSH && s_reg.pol == 2'h3 && !cmd_done
		|=> connected) else $error("policy 11 dropped bus");	// RULE17
	// disconnect mid-data only at block end
	a_blk_bound: assert property (@(posedge mclk) disable iff (!arst_n)
		disc_req && $past(s_reg.st) == sdrc_pkg::SDRC_XFER |->
		$past(blk_end && f_valid && f_ready)) else $error("mid-block disconnect");	// RULE5
	// reconnect for read only at or above threshold
	a_rd_thresh: assert property (@(posedge mclk) disable iff (!arst_n)
		reconn_req && s_reg.is_rd |-> $past(rd_ok))
		else $error("early read reconnect");	// RULE14
	// fairness follows field
	a_fair_map: assert property (@(posedge mclk) disable iff (!arst_n)
		prm_load && prm_fair == 3'h0 ##1 !prm_load ##1
		cmd_valid && !prm_load && s_reg.st == sdrc_pkg::SDRC_IDLE
		|=> !fair_arb) else $error("fairness with zero field");	// RULE19
	c_imm_disc:  cover property (@(posedge mclk) disable iff (!arst_n) disc_req ##[1:50] reconn_req);
	c_burst_end: cover property (@(posedge mclk) disable iff (!arst_n)
		s_reg.st == sdrc_pkg::SDRC_XFER ##1 disc_req);
	c_chk_err:   cover property (@(posedge mclk) disable iff (!arst_n) $rose(chk_cond));
endmodule

/* File: testbench/sdrc_init_model.sv */
// initiator model: grants or rejects disconnects and drains the data stream
`timescale 1ns/100ps
module sdrc_init_model (
	input  wire logic       mclk,	// clock
	input  wire logic       arst_n,	// async reset, low
	input  wire logic       grant_en,	// privilege given at identify
	input  wire logic       reject_en,	// answer disconnects with reject
	input  wire logic       slow,	// stall every other cycle
	input  wire logic [7:0] dat_out,	// word from target
	input  wire logic       dat_out_valid,	// target valid
	output logic            dat_out_ready,	// initiator ready
	output logic            disc_grant,	// disconnect privilege
	output logic            msg_reject	// reject disconnect request
);
	logic [7:0] got[$];	// words taken, in order

	// privilege and refusal follow the test's command
	assign disc_grant = grant_en;
	assign msg_reject = reject_en;

	// take words on handshake, stall when asked to be slow
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			dat_out_ready <= 1'b0;
		end else begin
			if (dat_out_valid && dat_out_ready) begin
				got.push_back(dat_out);
			end
			dat_out_ready <= slow ? ~dat_out_ready : 1'b1;
		end
	end
endmodule

/* File: testbench/tb_top.sv */
// self-checking bench for the disconnect/reconnect policy block
`timescale 1ns/100ps
module tb_top;
	logic        mclk = 1'b0;	// clock
	logic        arst_n = 1'b0;	// reset, low
	logic        prm_load = 1'b0;	// parameter strobe
	logic [3:0]  prm_notch = 4'h0;	// notch to load, 0 all
	logic [7:0]  prm_rd_ratio = 8'h00;	// read ratio
	logic [7:0]  prm_wr_ratio = 8'h00;	// write ratio
	logic [15:0] prm_burst = 16'h0000;	// burst limit
	logic        prm_disc_imm = 1'b0;	// disconnect at once
	logic [1:0]  prm_xfer_pol = 2'h0;	// transfer policy
	logic [2:0]  prm_fair = 3'h0;	// fairness field
	logic [3:0]  active_notch = 4'h0;	// zone in use
	logic [7:0]  opt_ratio = 8'h80;	// rate based ratio
	logic        cmd_valid = 1'b0;	// command strobe
	logic [7:0]  cmd_opcode = 8'h00;	// opcode
	logic        cmd_priority = 1'b0;	// priority command
	logic        cmd_queued = 1'b0;	// must queue
	logic        cmd_hit = 1'b0;	// data buffered
	logic [15:0] buf_fill = 16'h0000;	// fill count
	logic        cmd_done = 1'b0;	// command end strobe
	logic [15:0] xfer_blocks = 16'h0010;	// blocks left in command
	logic [7:0]  dat_in = 8'h00;	// source word
	logic        dat_in_valid = 1'b0;	// source valid
	logic        dat_last = 1'b0;	// block end
	logic        grant_en = 1'b1;	// initiator grants
	logic        reject_en = 1'b0;	// initiator rejects
	logic        slow = 1'b0;	// initiator stalls
	logic        dat_in_ready, dat_out_valid, dat_out_ready, disc_grant, msg_reject;
	logic        connected, disc_req, reconn_req, fair_arb, chk_cond;
	logic [7:0]  dat_out, sense_asc;	// data word, sense code
	logic [3:0]  sense_key;	// sense key
	logic [31:0] seed = 32'h234A88A0;	// xorshift state
	int          bad_count = 0, n_compared = 0, nd, nr, sc = 0;

	// 100 MHz clock
	always #5 mclk = ~mclk;

	sdrc_core #(.BUF_W(16), .NOTCHES(4), .DATA_W(8), .FIFO_D(4)) dut_u (
		.mclk(mclk), .arst_n(arst_n), .prm_load(prm_load), .prm_notch(prm_notch),
		.prm_rd_ratio(prm_rd_ratio), .prm_wr_ratio(prm_wr_ratio), .prm_burst(prm_burst),
		.prm_disc_imm(prm_disc_imm), .prm_xfer_pol(prm_xfer_pol), .prm_fair(prm_fair),
		.active_notch(active_notch), .opt_ratio(opt_ratio), .cmd_valid(cmd_valid),
		.cmd_opcode(cmd_opcode), .cmd_priority(cmd_priority), .cmd_queued(cmd_queued),
		.cmd_hit(cmd_hit), .disc_grant(disc_grant), .msg_reject(msg_reject),
		.buf_fill(buf_fill), .buf_size(16'h0100), .xfer_blocks(xfer_blocks),
		.cmd_done(cmd_done), .dat_in(dat_in), .dat_in_valid(dat_in_valid),
		.dat_in_ready(dat_in_ready), .dat_last(dat_last), .dat_out(dat_out),
		.dat_out_valid(dat_out_valid), .dat_out_ready(dat_out_ready),
		.connected(connected), .disc_req(disc_req), .reconn_req(reconn_req),
		.fair_arb(fair_arb), .chk_cond(chk_cond), .sense_key(sense_key),
		.sense_asc(sense_asc));

	sdrc_init_model init_u (
		.mclk(mclk), .arst_n(arst_n), .grant_en(grant_en), .reject_en(reject_en),
		.slow(slow), .dat_out(dat_out), .dat_out_valid(dat_out_valid),
		.dat_out_ready(dat_out_ready), .disc_grant(disc_grant), .msg_reject(msg_reject));

	// repeatable pseudo random source
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// verdict and end of run
	task automatic wrap_up();
		if (bad_count == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// single comparison point
	task automatic chk(input logic [15:0] seen, input logic [15:0] want);
		n_compared++;
		if (seen !== want) begin
			bad_count++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, want);
		end
	endtask

	// pulse reset for two cycles
	task automatic rst();
		@(posedge mclk);
		arst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		arst_n <= 1'b1;
	endtask

	// load the mode parameters, the ratios into the notch chosen by prm_notch, 0 for all
	task automatic setp(input logic [7:0] rd, wr, input logic [15:0] bur, input logic imm,
			input logic [1:0] pol, input logic [2:0] fr);
		@(posedge mclk);
		prm_load <= 1'b1;
		prm_rd_ratio <= rd;
		prm_wr_ratio <= wr;
		prm_burst <= bur;
		prm_disc_imm <= imm;
		prm_xfer_pol <= pol;
		prm_fair <= fr;
		@(posedge mclk);
		prm_load <= 1'b0;
	endtask

	// one command strobe
	task automatic cmd(input logic [7:0] op);
		@(posedge mclk);
		cmd_valid <= 1'b1;
		cmd_opcode <= op;
		@(posedge mclk);
		cmd_valid <= 1'b0;
	endtask

	// count request pulses over n cycles
	task automatic watch(input int n);
		nd = 0;
		nr = 0;
		repeat (n) begin
			@(negedge mclk);
			nd += int'(disc_req);
			nr += int'(reconn_req);
		end
	endtask

	// decision right after a command is taken
	task automatic scen(input logic [7:0] op, input logic imm, pri, q, hit, gr, rej,
			input logic [1:0] pol, input logic [15:0] bur, input int expd);
		logic c;
		c = (pol != 2'h0) && (bur != 16'h0000);
		rst();
		buf_fill <= 16'h00C8;
		setp(8'hFA, 8'h64, bur, imm, pol, sc[2:0]);
		cmd_priority <= pri;
		cmd_queued <= q;
		cmd_hit <= hit;
		grant_en <= gr;
		reject_en <= rej;
		cmd(op);
		watch(6);
		chk(16'(nd), 16'(expd));	// disconnect count
		chk(16'(chk_cond), 16'(c));
		chk(16'(fair_arb), 16'(sc[2:0] != 3'h0));
		if (c) begin
			chk(16'(sense_key), 16'h0005);
			chk(16'(sense_asc), 16'h0026);
			@(posedge mclk);
			cmd_done <= 1'b1;
			@(posedge mclk);
			cmd_done <= 1'b0;
			watch(3);
			chk(16'({chk_cond, connected}), 16'h0000);
		end
		grant_en <= 1'b1;
		reject_en <= 1'b0;
		sc++;
	endtask

	// reconnect exactly at the ratio threshold, buffer size 256
	task automatic thr(input logic rd, input logic zero);
		logic [7:0] r;
		logic [3:0] an;
		r = 8'h02 + 8'(rnd() % 254);
		an = 4'(rnd());
		rst();
		opt_ratio <= zero ? r : 8'h01;
		active_notch <= an;
		buf_fill <= rd ? 16'(r) - 16'h0001 : 16'h0101 - 16'(r);
		setp(zero ? 8'h00 : r, zero ? 8'h00 : r, 16'h0000, !rd, 2'h0, 3'h0);
		// another single notch gets a tiny ratio that must not reach the active one
		prm_notch <= (an[1:0] == 2'h1) ? 4'h2 : 4'h1;
		setp(8'h01, 8'h01, 16'h0000, !rd, 2'h0, 3'h0);
		prm_notch <= 4'h0;
		cmd_hit <= 1'b0;
		cmd_queued <= 1'b0;
		cmd_priority <= 1'b0;
		cmd(rd ? 8'h28 : 8'h2A);
		watch(6);
		chk(16'(nd), 16'h0001);
		chk(16'(nr), 16'h0000);
		@(posedge mclk);
		buf_fill <= rd ? 16'(r) : 16'h0100 - 16'(r);
		watch(4);
		chk(16'(nr), 16'h0001);
		chk(16'(connected), 16'h0001);
	endtask

	// fill the fifo until refused, then a buffered read drains all four words, or only the first two-word block where it disconnects or finishes
	task automatic data(input logic [15:0] bur, input logic [1:0] pol,
			input logic [15:0] fill, input int nw, ed);
		logic [7:0] w[4];
		logic       r;
		int         acc;
		rst();
		setp(8'hFA, 8'h64, bur, 1'b0, pol, 3'h0);
		init_u.got.delete();
		for (int i = 0; i < 4; i++) w[i] = 8'(rnd());
		acc = 0;
		slow <= 1'b1;
		buf_fill <= fill;
		xfer_blocks <= (pol != 2'h0) ? 16'h0001 : 16'h0010;	// policy runs end after one block
		cmd_hit <= 1'b1;
		cmd_queued <= 1'b0;
		cmd_priority <= 1'b0;
		dat_in <= w[0];
		dat_in_valid <= 1'b1;
		dat_last <= 1'b0;
		while (acc < 4) begin
			@(negedge mclk);
			r = dat_in_ready;
			@(posedge mclk);
			if (r) acc++;
			if (acc == 4) dat_in_valid <= 1'b0;
			dat_in <= w[acc % 4];
			dat_last <= acc[0];
		end
		@(negedge mclk);
		chk(16'(dat_in_ready), 16'h0000);	// full fifo refuses more
		chk(16'(acc), 16'h0004);	// four words held
		cmd(8'h08);
		watch(40);
		chk(16'(nd), 16'(ed));
		if (nw >= 0) chk(16'(init_u.got.size()), 16'(nw));
		for (int i = 0; i < init_u.got.size() && i < 4; i++) chk(16'(init_u.got[i]), 16'(w[i]));
		if (pol != 2'h0) begin
			chk(16'(connected), 16'(pol == 2'h3));
			@(posedge mclk);
			cmd_done <= 1'b1;
			@(posedge mclk);
			cmd_done <= 1'b0;
			@(negedge mclk);
			chk(16'(connected), 16'h0000);
		end
		slow <= 1'b0;
	endtask

	// main sequence
	initial begin
		repeat (2) @(posedge mclk);
		arst_n <= 1'b1;
		@(negedge mclk);
		chk(16'({connected, disc_req, reconn_req, chk_cond, dat_in_ready}), 16'h0001);
		scen(8'h0A, 0, 0, 0, 0, 1, 0, 2'h0, 16'h0000, 0);
		scen(8'h2A, 0, 0, 0, 0, 1, 0, 2'h0, 16'h0000, 0);
		scen(8'h2E, 0, 0, 0, 0, 1, 0, 2'h0, 16'h0000, 0);
		scen(8'h41, 0, 0, 0, 0, 1, 0, 2'h0, 16'h0000, 0);
		scen(8'h2A, 0, 0, 1, 0, 1, 0, 2'h0, 16'h0000, 1);
		scen(8'h0A, 1, 0, 0, 0, 1, 0, 2'h0, 16'h0000, 1);
		scen(8'h0A, 1, 1, 0, 0, 1, 0, 2'h0, 16'h0000, 0);
		scen(8'h0A, 1, 0, 0, 0, 0, 0, 2'h0, 16'h0000, 0);
		scen(8'h0A, 1, 0, 0, 0, 1, 1, 2'h0, 16'h0000, 0);
		scen(8'h08, 0, 0, 0, 1, 1, 0, 2'h0, 16'h0000, 0);
		scen(8'h28, 0, 0, 1, 1, 1, 0, 2'h0, 16'h0000, 1);
		scen(8'h08, 0, 0, 0, 0, 1, 0, 2'h0, 16'h0000, 1);
		scen(8'h28, 0, 0, 0, 1, 1, 0, 2'h1, 16'h0001, 0);
		scen(8'h28, 0, 0, 0, 1, 1, 0, 2'h3, 16'h0002, 0);
		scen(8'h28, 0, 0, 0, 1, 1, 0, 2'h1, 16'h0000, 0);
		scen(8'h08, 1, 0, 0, 1, 1, 0, 2'h0, 16'hFFFF, 1);
		scen(8'h28, 0, 0, 0, 1, 1, 0, 2'h2, 16'h0003, 0);
		for (int i = 0; i < 4; i++) thr(i[0], i[1]);
		data(16'h0000, 2'h0, 16'h00C8, 4, 0);
		data(16'h0001, 2'h0, 16'h00C8, 2, 1);
		data(16'h0000, 2'h0, 16'h0001, 2, 1);
		data(16'h0000, 2'h1, 16'h0001, 2, 1);
		data(16'h0000, 2'h3, 16'h0001, 2, 0);
		wrap_up();
	end

	// cut a hang short
	initial begin
		#200000;
		bad_count++;
		wrap_up();
	end
endmodule
